// ==== verilog/ppw_dev.sv ====
/*
 Peripheral end of the parallel port write handshake: takes address and data
 write cycles in standard, EPP and ECP signalling and answers on busy.
 Assumes a host that follows the handshake; mode and burst come from local
 configuration and change only while the link is idle.
*/
`timescale 1ns/100ps
module ppw_dev (
  input wire logic i_mclk,
  input wire logic i_rst,
  input ppw_pkg::ppw_mode_e i_mode,
  input wire logic i_burst,
  input wire logic i_sink_rdy,
  output logic [7:0] o_addr,
  output logic o_addr_vld,
  output logic o_wr_sel,
  output logic o_rd_sel,
  output ppw_pkg::ppw_target_e o_target,
  output logic [7:0] o_data,
  output logic o_data_vld,
  output logic o_data_drop,
  ppw_link_if.dev link
);
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_HOLD = 2'b01,
    DEV_XFER = 2'b10,
    DEV_REL = 2'b11
  } ppw_dev_state_e;

  ppw_dev_state_e state_r;
  ppw_dev_state_e state_nxt;
  logic [7:0] data_s;
  logic [2:0] ctrl_s;
  logic [2:0] ctrl_prev_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic ecp_addr_r;
  logic busy_r;
  logic busy_nxt;
  logic [7:0] addr_r;
  logic wr_sel_r;
  logic rd_sel_r;
  ppw_pkg::ppw_target_e tgt_r;
  logic [7:0] data_r;
  logic addr_vld_r;
  logic data_vld_r;
  logic drop_r;

  // Pins pass two flops before any edge logic sees them
  ppw_sync #(.W(8), .RST_VAL(ppw_pkg::BYTE_RST)) u_sync_data (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_d(link.data),
    .o_q(data_s)
  );
  ppw_sync #(.W(3), .RST_VAL(ppw_pkg::CTRL_IDLE)) u_sync_ctrl (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_d({link.auto_feed_n, link.sel_in_n, link.host_strobe_line_n}),
    .o_q(ctrl_s)
  );

  // Edge detection on the synchronised copies only
  wire stb_fall = ctrl_prev_r[0] & ~ctrl_s[0];
  wire stb_rise = ~ctrl_prev_r[0] & ctrl_s[0];
  wire sel_fall = ctrl_prev_r[1] & ~ctrl_s[1];
  wire alf_fall = ctrl_prev_r[2] & ~ctrl_s[2];
  wire lines_idle = ctrl_s[1] & ctrl_s[2];

  wire is_std = (i_mode == ppw_pkg::PPW_MODE_STD);
  wire is_epp = (i_mode == ppw_pkg::PPW_MODE_EPP);
  wire is_ecp = (i_mode == ppw_pkg::PPW_MODE_ECP);
  wire st_idle = (state_r == DEV_IDLE);

  // Data is acceptable only after a write-select address and with room
  wire accept_ok = wr_sel_r & i_sink_rdy;

  // Standard: select-in low latches the address with no hold-off
  wire std_addr = is_std & sel_fall;
  // Burst takes either strobe edge, otherwise only the falling one
  wire std_data = is_std & (stb_fall | (i_burst & stb_rise));
  wire epp_addr = is_epp & st_idle & sel_fall;
  wire epp_data = is_epp & st_idle & ~sel_fall & alf_fall;
  wire ecp_start = is_ecp & st_idle & stb_fall;
  wire ecp_end = (state_r == DEV_XFER) & stb_rise;
  // ECP latches on the rising strobe, the content kind taken at the fall
  wire ecp_addr = ecp_end & ecp_addr_r;
  wire ecp_data = ecp_end & ~ecp_addr_r;

  wire take_addr = std_addr | epp_addr | ecp_addr;
  wire take_data = std_data | epp_data | ecp_data;
  wire data_ok = take_data & accept_ok;
  // A byte that arrives without a write selection is dropped, not stored
  wire data_bad = take_data & ~accept_ok;

  // Address decode: direction and target
  wire addr_dir_wr = data_s[ppw_pkg::ADDR_DIR_BIT];
  wire [1:0] addr_tgt = data_s[ppw_pkg::ADDR_TGT_LSB +: ppw_pkg::ADDR_TGT_W];
  wire addr_tgt_ok = (addr_tgt != ppw_pkg::PPW_TGT_NONE);
  wire cnt_done = (cnt_r == ppw_pkg::CNT_ONE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      DEV_IDLE: begin
        if (epp_addr | epp_data) begin
          state_nxt = DEV_HOLD;
        end else if (ecp_start) begin
          state_nxt = DEV_XFER;
        end
      end
      DEV_HOLD: begin
        // Busy stays up until the host lets both lines go
        if (lines_idle) begin
          state_nxt = DEV_IDLE;
        end
      end
      DEV_XFER: begin
        if (stb_rise) begin
          state_nxt = DEV_REL;
          cnt_nxt = ppw_pkg::ECP_LOW_CYC;
        end
      end
      DEV_REL: begin
        // Low time long enough for the host's synchroniser to see it
        if (cnt_done) begin
          state_nxt = DEV_IDLE;
          cnt_nxt = ppw_pkg::CNT_ZERO;
        end else begin
          cnt_nxt = cnt_r - ppw_pkg::CNT_ONE;
        end
      end
      default: begin
        state_nxt = DEV_IDLE;
        cnt_nxt = ppw_pkg::CNT_ZERO;
      end
    endcase
  end

  // Busy: acknowledge while a cycle is open, low in the ECP release,
  // otherwise low exactly when a data byte can be taken
  always_comb begin
    case (state_nxt)
      DEV_HOLD: busy_nxt = 1'b1;
      DEV_XFER: busy_nxt = 1'b1;
      DEV_REL: busy_nxt = 1'b0;
      default: busy_nxt = ~accept_ok;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_r <= DEV_IDLE;
      cnt_r <= ppw_pkg::CNT_ZERO;
      ctrl_prev_r <= ppw_pkg::CTRL_IDLE;
      busy_r <= 1'b1;
      ecp_addr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ctrl_prev_r <= ctrl_s;
      busy_r <= busy_nxt;
      if (ecp_start) begin
        ecp_addr_r <= ~ctrl_s[2];
      end
    end
  end

  // Address latch and selection; a reserved target selects nothing
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      addr_r <= ppw_pkg::BYTE_RST;
      wr_sel_r <= 1'b0;
      rd_sel_r <= 1'b0;
      tgt_r <= ppw_pkg::PPW_TGT_NONE;
    end else if (take_addr) begin
      addr_r <= data_s;
      wr_sel_r <= addr_dir_wr & addr_tgt_ok;
      rd_sel_r <= ~addr_dir_wr & addr_tgt_ok;
      tgt_r <= ppw_pkg::ppw_target_e'(addr_tgt);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      data_r <= ppw_pkg::BYTE_RST;
      addr_vld_r <= 1'b0;
      data_vld_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      addr_vld_r <= take_addr;
      data_vld_r <= data_ok;
      drop_r <= data_bad;
      if (data_ok) begin
        data_r <= data_s;
      end
    end
  end

  assign link.peripheral_busy_line = busy_r;
  assign o_addr = addr_r;
  assign o_addr_vld = addr_vld_r;
  assign o_wr_sel = wr_sel_r;
  assign o_rd_sel = rd_sel_r;
  assign o_target = tgt_r;
  assign o_data = data_r;
  assign o_data_vld = data_vld_r;
  assign o_data_drop = drop_r;
endmodule // ppw_dev

// ==== verilog/ppw_pkg.sv ====
/*
 Shared constants for the parallel port write handshake: modes, address byte
 layout, reset levels and timing counts. Assumes a 25 MHz system clock.
*/
package ppw_pkg;
  localparam int CLK_NS = 40;
  localparam int STROBE_MIN_NS = 200;
  localparam int SETUP_MIN_NS = 125;
  localparam int ECP_LOW_MIN_NS = 160;
  // Least times round up to whole cycles
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] SETUP_CYC = 4'((SETUP_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] ECP_LOW_CYC = 4'((ECP_LOW_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  typedef enum logic [1:0] {
    PPW_MODE_STD = 2'b00,
    PPW_MODE_EPP = 2'b01,
    PPW_MODE_ECP = 2'b10
  } ppw_mode_e;

  // Address byte: bit 7 set selects write, bits 1:0 select the target
  localparam int ADDR_DIR_BIT = 7;
  localparam int ADDR_TGT_LSB = 0;
  localparam int ADDR_TGT_W = 2;
  typedef enum logic [1:0] {
    PPW_TGT_REG = 2'b00,
    PPW_TGT_DRAM = 2'b01,
    PPW_TGT_REMOTE = 2'b10,
    PPW_TGT_NONE = 2'b11
  } ppw_target_e;

  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] CTRL_IDLE = 3'h7;
endpackage

// ==== verilog/ppw_link_if.sv ====
/*
 Parallel port pins between the host port controller and the peripheral.
 Data runs host to peripheral only; strobe, select-in and auto-feed are
 active low, busy is active high.
*/
`timescale 1ns/100ps
interface ppw_link_if;
  logic [7:0] data;
  logic host_strobe_line_n;
  logic sel_in_n;
  logic auto_feed_n;
  logic peripheral_busy_line;

  modport dev (
    input data,
    input host_strobe_line_n,
    input sel_in_n,
    input auto_feed_n,
    output peripheral_busy_line
  );
  modport host (
    output data,
    output host_strobe_line_n,
    output sel_in_n,
    output auto_feed_n,
    input peripheral_busy_line
  );
endinterface

// ==== verilog/ppw_sync.sv ====
/*
 Two flip-flop synchroniser, one per bit, for pins from the other party.
 Assumes each bit changes slowly against the clock; bytes are held stable
 by the host well before the strobe that qualifies them.
*/
`timescale 1ns/100ps
module ppw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          meta_r <= RST_VAL[b];
          sync_r <= RST_VAL[b];
        end else begin
          meta_r <= i_d[b];
          sync_r <= meta_r;
        end
      end
      assign o_q[b] = sync_r;
    end
  endgenerate
endmodule // ppw_sync

// ==== verilog/ppw_host.sv ====
/*
 Host port end of the parallel port write handshake: turns address and data
 write requests into standard, EPP or ECP pin sequences.
 Assumes mode and burst are changed only while o_ready is high.
*/
`timescale 1ns/100ps
module ppw_host (
  input wire logic i_mclk,
  input wire logic i_rst,
  input ppw_pkg::ppw_mode_e i_mode,
  input wire logic i_burst,
  input wire logic i_req,
  input wire logic i_is_addr,
  input wire logic [7:0] i_byte,
  output logic o_ready,
  output logic o_done,
  ppw_link_if.host link
);
  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_SETUP = 3'b001,
    HST_PULSE = 3'b010,
    HST_WAIT_HI = 3'b011,
    HST_WAIT_LO = 3'b100,
    HST_RECOV = 3'b101
  } ppw_host_state_e;

  ppw_host_state_e state_r;
  logic [3:0] cnt_r;
  logic is_addr_r;
  logic [7:0] data_r;
  logic stb_r;
  logic sel_r;
  logic alf_r;
  logic done_r;
  logic busy_s;

  ppw_sync #(.W(1), .RST_VAL(1'b1)) u_sync_busy (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_d(link.peripheral_busy_line),
    .o_q(busy_s)
  );

  wire is_std = (i_mode == ppw_pkg::PPW_MODE_STD);
  wire is_epp = (i_mode == ppw_pkg::PPW_MODE_EPP);
  wire cnt_done = (cnt_r == ppw_pkg::CNT_ONE);
  wire [3:0] cnt_dec = cnt_r - ppw_pkg::CNT_ONE;
  // Address requests are taken whatever busy is; data waits for busy low
  assign o_ready = (state_r == HST_IDLE) & (i_is_addr | ~busy_s);
  wire take = i_req & o_ready;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_r <= HST_IDLE;
      cnt_r <= ppw_pkg::CNT_ZERO;
      is_addr_r <= 1'b0;
      data_r <= ppw_pkg::BYTE_RST;
      stb_r <= 1'b1;
      sel_r <= 1'b1;
      alf_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        HST_IDLE: begin
          if (take) begin
            state_r <= HST_SETUP;
            cnt_r <= ppw_pkg::SETUP_CYC;
            is_addr_r <= i_is_addr;
            data_r <= i_byte;
            // ECP marks address content with auto-feed low
            alf_r <= ~(i_is_addr & (i_mode == ppw_pkg::PPW_MODE_ECP));
          end
        end
        HST_SETUP: begin
          if (!cnt_done) begin
            cnt_r <= cnt_dec[3:0];
          end else if (is_std & !is_addr_r & i_burst) begin
            // Burst: one toggle per byte
            stb_r <= ~stb_r;
            state_r <= HST_RECOV;
            cnt_r <= ppw_pkg::STROBE_CYC;
          end else if (is_std) begin
            sel_r <= ~is_addr_r;
            stb_r <= is_addr_r;
            state_r <= HST_PULSE;
            cnt_r <= ppw_pkg::STROBE_CYC;
          end else if (is_epp) begin
            sel_r <= ~is_addr_r;
            alf_r <= is_addr_r;
            state_r <= HST_WAIT_HI;
          end else begin
            stb_r <= 1'b0;
            state_r <= HST_WAIT_HI;
          end
        end
        HST_PULSE: begin
          if (cnt_done) begin
            sel_r <= 1'b1;
            stb_r <= 1'b1;
            state_r <= HST_RECOV;
            cnt_r <= ppw_pkg::STROBE_CYC;
          end else begin
            cnt_r <= cnt_dec[3:0];
          end
        end
        HST_WAIT_HI: begin
          // Cycle ends only once busy acknowledges
          if (busy_s) begin
            sel_r <= 1'b1;
            stb_r <= 1'b1;
            if (is_epp) begin
              alf_r <= 1'b1;
              state_r <= HST_RECOV;
              cnt_r <= ppw_pkg::STROBE_CYC;
            end else begin
              state_r <= HST_WAIT_LO;
            end
          end
        end
        HST_WAIT_LO: begin
          // ECP: the device latches on the strobe rise and drops busy
          if (!busy_s) begin
            alf_r <= 1'b1;
            state_r <= HST_RECOV;
            cnt_r <= ppw_pkg::STROBE_CYC;
          end
        end
        HST_RECOV: begin
          if (cnt_done) begin
            done_r <= 1'b1;
            state_r <= HST_IDLE;
            cnt_r <= ppw_pkg::CNT_ZERO;
          end else begin
            cnt_r <= cnt_dec[3:0];
          end
        end
        default: begin
          state_r <= HST_IDLE;
        end
      endcase
    end
  end

  assign link.data = data_r;
  assign link.host_strobe_line_n = stb_r;
  assign link.sel_in_n = sel_r;
  assign link.auto_feed_n = alf_r;
  assign o_done = done_r;
endmodule // ppw_host

// ==== sim/ppw_link_sva.sv ====
/*
 Concurrent checks on the link between the host and peripheral ends.
 Assumes one clock, a synchronous active-high reset, and mode and burst
 changed only while the link is idle.
*/
`timescale 1ns/100ps
module ppw_link_sva (
  input wire logic i_mclk,
  input wire logic i_rst,
  input ppw_pkg::ppw_mode_e i_mode,
  input wire logic i_burst,
  input wire logic [7:0] data,
  input wire logic host_strobe_line_n,
  input wire logic sel_in_n,
  input wire logic auto_feed_n,
  input wire logic peripheral_busy_line,
  input wire logic o_addr_vld,
  input wire logic o_data_vld,
  input wire logic o_data_drop
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  wire is_std = (i_mode == ppw_pkg::PPW_MODE_STD);
  wire is_epp = (i_mode == ppw_pkg::PPW_MODE_EPP);
  wire is_ecp = (i_mode == ppw_pkg::PPW_MODE_ECP);
  // Sync plus edge detect and the busy flop give three cycles; eight leaves margin
  sequence s_busy_up;
    ##[1:8] peripheral_busy_line;
  endsequence
  sequence s_busy_down_hold;
    ##[1:8] $fell(peripheral_busy_line) ##1 !peripheral_busy_line [*3];
  endsequence

  AST_RST_IDLE: assert property ($fell(i_rst) |-> peripheral_busy_line &&
    host_strobe_line_n && sel_in_n && auto_feed_n && data == ppw_pkg::BYTE_RST)
    else $error("link not idle after reset");
  AST_STD_SEL_WIDTH: assert property (is_std && $fell(sel_in_n) |->
    !sel_in_n [*5]) else $error("select-in pulse too short");
  AST_STD_STB_WIDTH: assert property (is_std && !i_burst && $fell(host_strobe_line_n)
    |-> !host_strobe_line_n [*5]) else $error("strobe pulse too short");
  AST_ADDR_TAKEN: assert property (!is_ecp && $fell(sel_in_n) |->
    ##[2:6] o_addr_vld) else $error("address not taken");
  AST_EPP_ACK: assert property (is_epp && ($fell(sel_in_n) || $fell(auto_feed_n))
    |-> s_busy_up) else $error("EPP busy not raised");
  AST_EPP_HOLD: assert property (is_epp && !auto_feed_n && !peripheral_busy_line
    |=> !auto_feed_n) else $error("EPP cycle ended before busy");
  AST_ECP_MARK: assert property (is_ecp && $fell(host_strobe_line_n) |->
    $stable(auto_feed_n) && $stable(data)) else $error("ECP byte or mark moved");
  AST_ECP_OPEN: assert property (is_ecp && $fell(host_strobe_line_n) |->
    s_busy_up) else $error("ECP busy not raised");
  AST_ECP_CLOSE: assert property (is_ecp && $rose(host_strobe_line_n) |->
    s_busy_down_hold) else $error("ECP busy not lowered");
  AST_BURST_EDGE: assert property (is_std && i_burst && $changed(host_strobe_line_n)
    |-> ##[2:6] (o_data_vld || o_data_drop)) else $error("burst edge lost");
  AST_VLD_PULSE: assert property (o_data_vld || o_addr_vld |=>
    !o_data_vld && !o_addr_vld) else $error("strobe acted on twice");
endmodule // ppw_link_sva

// ==== sim/parallel_port_write_handshake_test.sv ====
/*
 Self-checking bench: host and peripheral ends joined by one link.
 Assumes one shared clock and synchronous reset for both ends.
*/
`timescale 1ns/100ps
module parallel_port_write_handshake_test;
  logic i_mclk;
  logic i_rst;
  ppw_pkg::ppw_mode_e mode;
  logic burst;
  logic sink_rdy;
  logic req;
  logic is_addr;
  logic [7:0] tx_byte;
  logic ready;
  logic done;
  logic [7:0] addr;
  logic addr_vld;
  logic wr_sel;
  logic rd_sel;
  ppw_pkg::ppw_target_e target;
  logic [7:0] data;
  logic data_vld;
  logic data_drop;
  logic [7:0] rx_q[$];
  int errors;
  int checked;
  int cycles;
  int drops;
  ppw_link_if link ();
  ppw_host ppw_host_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_mode(mode), .i_burst(burst),
    .i_req(req), .i_is_addr(is_addr), .i_byte(tx_byte), .o_ready(ready), .o_done(done),
    .link(link));
  ppw_dev ppw_dev_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_mode(mode), .i_burst(burst),
    .i_sink_rdy(sink_rdy), .o_addr(addr), .o_addr_vld(addr_vld), .o_wr_sel(wr_sel),
    .o_rd_sel(rd_sel), .o_target(target), .o_data(data), .o_data_vld(data_vld),
    .o_data_drop(data_drop), .link(link));
  ppw_link_sva ppw_link_sva_i (.i_mclk(i_mclk), .i_rst(i_rst), .i_mode(mode),
    .i_burst(burst), .data(link.data), .host_strobe_line_n(link.host_strobe_line_n),
    .sel_in_n(link.sel_in_n), .auto_feed_n(link.auto_feed_n),
    .peripheral_busy_line(link.peripheral_busy_line), .o_addr_vld(addr_vld),
    .o_data_vld(data_vld), .o_data_drop(data_drop));

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  // Sample on the falling edge so registered outputs have settled
  always @(negedge i_mclk) begin
    if (data_vld === 1'b1) begin
      rx_q.push_back(data);
    end
    if (data_drop === 1'b1) begin
      drops++;
    end
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Data requests stay refused while busy is high, so wait is bounded
  task automatic send(input logic a, input logic [7:0] b);
    int n;
    n = 0;
    is_addr = a;
    tx_byte = b;
    while (ready !== 1'b1 && n < 200) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    req = 1'b1;
    @(posedge i_mclk);
    #1;
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk("cycle done", 8'h01, 8'(done));
  endtask
  task automatic expect_rx(input logic [7:0] exp);
    int n;
    n = 0;
    while (rx_q.size() == 0 && n < 20) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    if (rx_q.size() == 0) begin
      chk("rx byte count", 8'h01, 8'h00);
    end else begin
      chk("rx byte", exp, rx_q.pop_front());
    end
  endtask
  task automatic wait_busy(input logic exp);
    int n;
    n = 0;
    while (link.peripheral_busy_line !== exp && n < 12) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    chk("busy", 8'(exp), 8'(link.peripheral_busy_line));
  endtask

  task automatic t_reset();
    chk("busy after reset", 8'h01, 8'(link.peripheral_busy_line));
    chk("controls idle", 8'h07, {5'h00, link.host_strobe_line_n, link.sel_in_n,
      link.auto_feed_n});
  endtask
  task automatic t_std_write();
    send(1'b1, 8'h81);
    chk("address", 8'h81, addr);
    chk("write select", 8'h01, 8'(wr_sel));
    chk("target", 8'(ppw_pkg::PPW_TGT_DRAM), 8'(target));
    wait_busy(1'b0);
    send(1'b0, 8'h3C);
    send(1'b0, 8'hC3);
    expect_rx(8'h3C);
    expect_rx(8'hC3);
  endtask
  task automatic t_stall();
    sink_rdy = 1'b0;
    wait_busy(1'b1);
    sink_rdy = 1'b1;
    wait_busy(1'b0);
    // Sink goes away after the host has taken the byte: it must be dropped
    fork
      send(1'b0, 8'h55);
      begin
        wait (req === 1'b1);
        @(posedge i_mclk);
        #1;
        sink_rdy = 1'b0;
      end
    join
    chk("drop pulses", 8'h01, 8'(drops));
    chk("bytes after drop", 8'h00, 8'(rx_q.size()));
    sink_rdy = 1'b1;
    wait_busy(1'b0);
  endtask
  task automatic t_select();
    send(1'b1, 8'h02);
    chk("read select", 8'h02, 8'({rd_sel, wr_sel}));
    wait_busy(1'b1);
    is_addr = 1'b0;
    @(posedge i_mclk);
    #1;
    chk("data refused", 8'h00, 8'(ready));
    send(1'b1, 8'h83);
    chk("no select", 8'h00, 8'({rd_sel, wr_sel}));
    chk("no target", 8'(ppw_pkg::PPW_TGT_NONE), 8'(target));
  endtask
  // Even byte count leaves strobe high for the later non-burst cycles
  task automatic t_burst();
    send(1'b1, 8'h80);
    burst = 1'b1;
    for (int i = 0; i < 4; i++) begin
      send(1'b0, 8'(8'h10 + i));
      expect_rx(8'(8'h10 + i));
      chk("strobe level", 8'(i & 1), 8'(link.host_strobe_line_n));
    end
    burst = 1'b0;
  endtask
  task automatic t_modes();
    for (int i = 0; i < 3; i++) begin
      mode = ppw_pkg::ppw_mode_e'(i[1:0]);
      send(1'b1, {1'b1, 5'h00, i[1:0]});
      chk("mode target", {6'h00, i[1:0]}, 8'(target));
      send(1'b0, 8'(8'hA0 + i));
      expect_rx(8'(8'hA0 + i));
      wait_busy(1'b0);
    end
  endtask

  initial begin
    i_rst = 1'b1;
    mode = ppw_pkg::PPW_MODE_STD;
    burst = 1'b0;
    sink_rdy = 1'b1;
    req = 1'b0;
    is_addr = 1'b1;
    tx_byte = 8'h00;
    errors = 0;
    checked = 0;
    cycles = 0;
    drops = 0;
    repeat (10) @(posedge i_mclk);
    #1;
    i_rst = 1'b0;
    t_reset();
    t_std_write();
    t_stall();
    t_select();
    t_burst();
    t_modes();
    give_verdict();
  end
endmodule // parallel_port_write_handshake_test
